// file: design/pgcfg_defines.svh
`ifndef PGCFG_DEFINES_SVH
`define PGCFG_DEFINES_SVH

// ==========================================================
// Register indices (byte address is four times the index)
`define PGCFG_IDX_WINDOW 6'h16
`define PGCFG_IDX_PIN_CTRL 6'h17
`define PGCFG_IDX_SRC_A 6'h18
`define PGCFG_IDX_FAULT_A 6'h19
`define PGCFG_IDX_SRC_B 6'h1a
`define PGCFG_IDX_FAULT_B 6'h1b
`define PGCFG_IDX_IRQ_STAT 6'h1c
`define PGCFG_IDX_IRQ_MASK 6'h1d

// ==========================================================
// Reset values before the programmed defaults load
`define PGCFG_RST_WINDOW 8'h00
`define PGCFG_RST_PIN_CTRL 8'h02
`define PGCFG_RST_SRC 8'h00

// ==========================================================
// Field positions
`define PGCFG_WIN_BOOST_HI 7
`define PGCFG_WIN_BOOST_LO 6
`define PGCFG_WIN_THR_HI 5
`define PGCFG_WIN_THR_LO 4
`define PGCFG_WIN_SD2_HI 3
`define PGCFG_WIN_SD2_LO 2
`define PGCFG_WIN_SD1_HI 1
`define PGCFG_WIN_SD1_LO 0
`define PGCFG_B_MODE 7
`define PGCFG_B_GATING 6
`define PGCFG_B_RSVD 5
`define PGCFG_B_POL 4
`define PGCFG_A_MODE 3
`define PGCFG_A_GATING 2
`define PGCFG_A_DRIVE 1
`define PGCFG_A_POL 0
`define PGCFG_SRC_DELAY 7
`define PGCFG_SRC_THERMAL 6
`define PGCFG_IRQ_FAULT_A 0
`define PGCFG_IRQ_FAULT_B 1
`define PGCFG_IRQ_LOST_A 2

// ==========================================================
// Timing
`define PGCFG_RISE_DELAY_MS 11
`define PGCFG_CLK_KHZ 250000

`endif

// file: design/pgcfg_pkg.sv
package pgcfg_pkg;
   // Source order: first step-down, second step-down, step-up, monitor a, monitor b, analog, thermal
   typedef logic [6:0] pgcfg_src_t;
   typedef logic [7:0] pgcfg_byte_t;
   typedef logic [2:0] pgcfg_irq_t;
endpackage

// file: design/pgcfg_rise_delay.sv
`timescale 1ns/100ps
module pgcfg_rise_delay #(
   parameter int DELAY_CYCLES = 2750000
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Control
   input wire logic enable,
   input wire logic valid_in,
   // Result
   output logic valid_out
);
   localparam int CW = $clog2(DELAY_CYCLES + 1);
   // Count runs to the full figure so the extra wait is exactly DELAY_CYCLES
   localparam logic [CW-1:0] LAST = CW'(DELAY_CYCLES);

   logic [CW-1:0] cnt_q;
   logic valid_q;

   assign valid_out = valid_q;

   // Falling edges pass at once, rising edges wait out the count
   always_ff @(posedge clk)
   begin
      if (rst || !valid_in)
      begin
         cnt_q <= '0;
         valid_q <= 1'b0;
      end
      else if (!enable)
      begin
         cnt_q <= '0;
         valid_q <= 1'b1;
      end
      else if (!valid_q)
      begin
         if (cnt_q == LAST)
            valid_q <= 1'b1;
         else
            cnt_q <= cnt_q + CW'(1);
      end
   end
endmodule

// file: design/pgcfg_top.sv
// What this block does
// - Bits 7 to 6 of the window register hold the step-up window code, codes 0 to 3 meaning 2, 4, 6 and 8 percent.
// - Bits 3 to 2 hold the second step-down window code, codes 0 to 3 meaning 30, 50, 70 and 90 mV.
// - Bits 1 to 0 hold the first step-down window code with the same four millivolt codes.
// - Every configuration field loads its power-up default from programmed memory; bits 5 to 4 hold a step-up threshold code passed on as is.
// - Control bit 7 picks the second pin's mode: unusual-situation detection or showing outputs not yet valid.
// - Control bit 6 makes the second pin follow live sources when clear, or its fault latches when set, inactive while any is set.
// - Control bit 4 sets the second pin polarity: clear drives high when valid, set drives low when valid.
// - Control bit 3 picks the first pin's mode in the same way as bit 7 does for the second pin.
// - Control bit 2 makes the first pin follow live sources or its fault latches, inactive while any is set.
// - Control bit 1 picks the first pin drive, push-pull when clear and open-drain when set, resetting to one.
// - Control bit 0 sets the first pin polarity: clear drives high when valid, set drives low when valid.
// - The first source register holds rise delay in bit 7, thermal select in bit 6 and six rail selects in bits 5 to 0, all resetting to zero.
// - With rise delay set the first pin's move to valid waits 11 ms; with it clear there is no wait.
// - A clear select bit masks its rail from the pin, a set one lets the rail's result act on it.
// - A fault bit latches when its selected source makes the pin inactive and is cleared by writing one only while that source is valid.
// - The thermal select bit lets a thermal warning act on the first pin or masks it.
`timescale 1ns/100ps
`include "pgcfg_defines.svh"
module pgcfg_top #(
   parameter int RISE_DELAY_CYCLES = `PGCFG_RISE_DELAY_MS * `PGCFG_CLK_KHZ
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Programmed defaults
   input wire pgcfg_pkg::pgcfg_byte_t otp_window_i,
   input wire pgcfg_pkg::pgcfg_byte_t otp_pin_ctrl_i,
   input wire pgcfg_pkg::pgcfg_byte_t otp_src_a_i,
   input wire pgcfg_pkg::pgcfg_byte_t otp_src_b_i,
   // Monitor results, asynchronous
   input wire logic [5:0] rail_good_i,
   input wire logic thermal_warning_i,
   // Threshold codes to the comparators
   output logic [1:0] step_up_window_code_o,
   output logic [1:0] step_up_threshold_code_o,
   output logic [1:0] second_step_down_window_code_o,
   output logic [1:0] first_step_down_window_code_o,
   // Pins
   output logic first_good_pin_o,
   output logic first_good_pin_oe,
   output logic second_good_pin_o,
   // Interrupt
   output logic irq_o
);
   import pgcfg_pkg::*;

   // ==========================================================
   // Register storage
   pgcfg_byte_t win_q, ctrl_q, src_a_q, src_b_q;
   pgcfg_src_t fault_a_q, fault_b_q;
   pgcfg_irq_t irq_stat_q, irq_mask_q;
   logic loaded_q, ack_q, irq_q;
   logic [31:0] rdat_q;
   logic pin_a_q, pin_a_oe_q, pin_b_q;
   logic armed_a_q, armed_b_q, valid_a_prev_q;

   // ==========================================================
   // Bus decode
   logic req, wr;
   logic [5:0] idx;
   assign req = wb_cyc_i && wb_stb_i && !ack_q;
   assign wr = req && wb_we_i && wb_sel_i[0];
   assign idx = wb_adr_i[7:2];

   // ==========================================================
   // Source synchroniser; thermal result inverted to a good level
   pgcfg_src_t good_meta_q, good_q;
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         good_meta_q <= '0;
         good_q <= '0;
      end
      else
      begin
         good_meta_q <= {!thermal_warning_i, rail_good_i};
         good_q <= good_meta_q;
      end
   end

   // ==========================================================
   // Configuration registers; defaults land one cycle after release
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         win_q <= `PGCFG_RST_WINDOW;
         ctrl_q <= `PGCFG_RST_PIN_CTRL;
         src_a_q <= `PGCFG_RST_SRC;
         src_b_q <= `PGCFG_RST_SRC;
         loaded_q <= 1'b0;
      end
      else if (!loaded_q)
      begin
         win_q <= otp_window_i;
         ctrl_q <= otp_pin_ctrl_i;
         src_a_q <= otp_src_a_i;
         src_b_q <= otp_src_b_i;
         loaded_q <= 1'b1;
      end
      else if (wr)
      begin
         if (idx == `PGCFG_IDX_WINDOW)
            win_q <= wb_dat_i[7:0];
         if (idx == `PGCFG_IDX_PIN_CTRL)
            ctrl_q <= wb_dat_i[7:0];
         if (idx == `PGCFG_IDX_SRC_A)
            src_a_q <= wb_dat_i[7:0];
         if (idx == `PGCFG_IDX_SRC_B)
            src_b_q <= wb_dat_i[7:0];
      end
   end

   assign step_up_window_code_o = win_q[`PGCFG_WIN_BOOST_HI:`PGCFG_WIN_BOOST_LO];
   assign step_up_threshold_code_o = win_q[`PGCFG_WIN_THR_HI:`PGCFG_WIN_THR_LO];
   assign second_step_down_window_code_o = win_q[`PGCFG_WIN_SD2_HI:`PGCFG_WIN_SD2_LO];
   assign first_step_down_window_code_o = win_q[`PGCFG_WIN_SD1_HI:`PGCFG_WIN_SD1_LO];

   // ==========================================================
   // Valid indication per pin
   pgcfg_src_t sel_a, sel_b, bad_a, bad_b, clr_a, clr_b;
   logic live_a, live_b, valid_a, valid_b, valid_a_dly;
   assign sel_a = src_a_q[6:0];
   assign sel_b = src_b_q[6:0];
   assign bad_a = sel_a & ~good_q;
   assign bad_b = sel_b & ~good_q;
   assign live_a = ~|bad_a;
   assign live_b = ~|bad_b;
   // Held invalid until the defaults load, so no false rise and fall at start-up
   assign valid_a = loaded_q && (ctrl_q[`PGCFG_A_GATING] ? ~|fault_a_q : live_a);
   assign valid_b = loaded_q && (ctrl_q[`PGCFG_B_GATING] ? ~|fault_b_q : live_b);
   assign clr_a = (wr && idx == `PGCFG_IDX_FAULT_A) ? wb_dat_i[6:0] & good_q : '0;
   assign clr_b = (wr && idx == `PGCFG_IDX_FAULT_B) ? wb_dat_i[6:0] & good_q : '0;

   // Detection mode ignores start-up: latches arm once all selected sources have been good
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         armed_a_q <= 1'b0;
         armed_b_q <= 1'b0;
      end
      else
      begin
         // Not before the load: the reset-time empty selects would arm falsely
         armed_a_q <= armed_a_q || (loaded_q && (live_a || ctrl_q[`PGCFG_A_MODE]));
         armed_b_q <= armed_b_q || (loaded_q && (live_b || ctrl_q[`PGCFG_B_MODE]));
      end
   end

   // Fault latches; a set in the clearing cycle wins
   genvar gi;
   generate
      for (gi = 0; gi < 7; gi++)
      begin : g_fault
         always_ff @(posedge clk)
         begin
            if (rst)
            begin
               fault_a_q[gi] <= 1'b0;
               fault_b_q[gi] <= 1'b0;
            end
            else
            begin
               fault_a_q[gi] <= (bad_a[gi] && armed_a_q) || (fault_a_q[gi] && !clr_a[gi]);
               fault_b_q[gi] <= (bad_b[gi] && armed_b_q) || (fault_b_q[gi] && !clr_b[gi]);
            end
         end
      end
   endgenerate

   pgcfg_rise_delay #(
      .DELAY_CYCLES(RISE_DELAY_CYCLES)
   ) u_rise_delay (
      .clk(clk),
      .rst(rst),
      .enable(src_a_q[`PGCFG_SRC_DELAY]),
      .valid_in(valid_a),
      .valid_out(valid_a_dly)
   );

   // ==========================================================
   // Pin shaping; open-drain never drives high
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         pin_a_q <= 1'b0;
         pin_a_oe_q <= 1'b0;
         pin_b_q <= 1'b0;
      end
      else
      begin
         pin_b_q <= valid_b ^ ctrl_q[`PGCFG_B_POL];
         if (ctrl_q[`PGCFG_A_DRIVE])
         begin
            pin_a_q <= 1'b0;
            pin_a_oe_q <= !(valid_a_dly ^ ctrl_q[`PGCFG_A_POL]);
         end
         else
         begin
            pin_a_q <= valid_a_dly ^ ctrl_q[`PGCFG_A_POL];
            pin_a_oe_q <= 1'b1;
         end
      end
   end

   assign first_good_pin_o = pin_a_q;
   assign first_good_pin_oe = pin_a_oe_q;
   assign second_good_pin_o = pin_b_q;

   // ==========================================================
   // Interrupt status and mask
   pgcfg_irq_t irq_ev, irq_clr;
   assign irq_ev[`PGCFG_IRQ_FAULT_A] = |((bad_a & {7{armed_a_q}}) & ~fault_a_q);
   assign irq_ev[`PGCFG_IRQ_FAULT_B] = |((bad_b & {7{armed_b_q}}) & ~fault_b_q);
   assign irq_ev[`PGCFG_IRQ_LOST_A] = valid_a_prev_q && !valid_a_dly;
   assign irq_clr = (wr && idx == `PGCFG_IDX_IRQ_STAT) ? wb_dat_i[2:0] : '0;

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         irq_stat_q <= '0;
         irq_mask_q <= '0;
         irq_q <= 1'b0;
         valid_a_prev_q <= 1'b0;
      end
      else
      begin
         valid_a_prev_q <= valid_a_dly;
         irq_stat_q <= irq_ev | (irq_stat_q & ~irq_clr);
         if (wr && idx == `PGCFG_IDX_IRQ_MASK)
            irq_mask_q <= wb_dat_i[2:0];
         irq_q <= |(irq_stat_q & irq_mask_q);
      end
   end
   assign irq_o = irq_q;

   // ==========================================================
   // Read path; unmapped addresses answer zero
   logic [7:0] rd;
   always_comb
   begin
      rd = 8'h00;
      unique case (idx)
         `PGCFG_IDX_WINDOW: rd = win_q;
         `PGCFG_IDX_PIN_CTRL: rd = ctrl_q;
         `PGCFG_IDX_SRC_A: rd = src_a_q;
         `PGCFG_IDX_FAULT_A: rd = {1'b0, fault_a_q};
         `PGCFG_IDX_SRC_B: rd = src_b_q;
         `PGCFG_IDX_FAULT_B: rd = {1'b0, fault_b_q};
         `PGCFG_IDX_IRQ_STAT: rd = {5'h00, irq_stat_q};
         `PGCFG_IDX_IRQ_MASK: rd = {5'h00, irq_mask_q};
         default: rd = 8'h00;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         ack_q <= 1'b0;
         rdat_q <= '0;
      end
      else
      begin
         ack_q <= req;
         if (req)
            rdat_q <= {24'h000000, rd};
      end
   end
   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_win_write;
      (wr && idx == `PGCFG_IDX_WINDOW && loaded_q) |=> win_q == $past(wb_dat_i[7:0]);
   endproperty
   a_win_write: assert property (p_win_write) else $error("window write lost");

   property p_sd_codes;
      (wr && idx == `PGCFG_IDX_WINDOW && loaded_q) |=>
         second_step_down_window_code_o == $past(wb_dat_i[3:2]) && first_step_down_window_code_o == $past(wb_dat_i[1:0]);
   endproperty
   a_sd_codes: assert property (p_sd_codes) else $error("step-down codes wrong");

   property p_otp_load;
      (!rst && !loaded_q) |=> ctrl_q == $past(otp_pin_ctrl_i) && src_a_q == $past(otp_src_a_i) && win_q == $past(otp_window_i);
   endproperty
   a_otp_load: assert property (p_otp_load) else $error("defaults not loaded");

   property p_pol_b;
      !rst |=> second_good_pin_o == $past(valid_b ^ ctrl_q[`PGCFG_B_POL]);
   endproperty
   a_pol_b: assert property (p_pol_b) else $error("second pin level wrong");

   property p_gate_a;
      (ctrl_q[`PGCFG_A_GATING] && |fault_a_q) |-> !valid_a;
   endproperty
   a_gate_a: assert property (p_gate_a) else $error("first pin valid despite fault");

   property p_open_drain;
      $past(ctrl_q[`PGCFG_A_DRIVE]) |-> !first_good_pin_o;
   endproperty
   a_open_drain: assert property (p_open_drain) else $error("open-drain pin driven high");

   property p_no_delay;
      (!rst && !src_a_q[`PGCFG_SRC_DELAY] && valid_a) ##1 (!src_a_q[`PGCFG_SRC_DELAY] && valid_a) |-> valid_a_dly;
   endproperty
   a_no_delay: assert property (p_no_delay) else $error("undelayed rise held back");

   property p_mask;
      (!sel_a[0] && !fault_a_q[0] && !clr_a[0]) |=> !fault_a_q[0];
   endproperty
   a_mask: assert property (p_mask) else $error("masked source latched");

   property p_clear_blocked;
      (fault_a_q[0] && !good_q[0] && wr && idx == `PGCFG_IDX_FAULT_A && wb_dat_i[0]) |=> fault_a_q[0];
   endproperty
   a_clear_blocked: assert property (p_clear_blocked) else $error("fault cleared while source bad");

   c_delayed_rise: cover property (src_a_q[`PGCFG_SRC_DELAY] && $rose(valid_a_dly));
   c_fault_latch: cover property ($rose(fault_a_q[6]));
   c_irq: cover property ($rose(irq_o));
endmodule

// file: testbench/pgcfg_pin_sampler.sv
`timescale 1ns/100ps
// ==========================================
// Board logic that samples the indication pins
module pgcfg_pin_sampler (
   // Pins from the block
   input wire logic first_pin_o,
   input wire logic first_pin_oe,
   input wire logic second_pin_o,
   // Levels seen on the board
   output logic first_wire,
   output logic second_wire
);
   // Pull-up owns the node whenever the block lets go
   assign first_wire = first_pin_oe ? first_pin_o : 1'b1;
   assign second_wire = second_pin_o;
endmodule

// file: testbench/test_power_good_output_config.sv
`timescale 1ns/100ps
module test_power_good_output_config;
   localparam int RD = 20;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic wb_cyc = 1'b0;
   logic wb_stb = 1'b0;
   logic wb_we = 1'b0;
   logic [7:0] wb_adr = 8'h00;
   logic [3:0] wb_sel = 4'h0;
   logic [31:0] wb_wdat = 32'h0;
   logic [31:0] wb_rdat;
   logic wb_ack;
   logic [7:0] otp [4] = '{default: 8'h00};
   logic [5:0] rail_good = 6'h3f;
   logic thermal = 1'b0;
   logic [1:0] c_bw, c_bt, c_s2, c_s1;
   logic pin_a_o, pin_a_oe, pin_b_o, irq, wire_a, wire_b;
   int err_total = 0;
   int cmp_count = 0;
   int reg_m [64];

   pgcfg_top #(.RISE_DELAY_CYCLES(RD)) dut_u (
      .clk(clk), .rst(rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
      .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
      .otp_window_i(otp[0]), .otp_pin_ctrl_i(otp[1]), .otp_src_a_i(otp[2]), .otp_src_b_i(otp[3]),
      .rail_good_i(rail_good), .thermal_warning_i(thermal), .step_up_window_code_o(c_bw),
      .step_up_threshold_code_o(c_bt), .second_step_down_window_code_o(c_s2),
      .first_step_down_window_code_o(c_s1), .first_good_pin_o(pin_a_o), .first_good_pin_oe(pin_a_oe),
      .second_good_pin_o(pin_b_o), .irq_o(irq));

   pgcfg_pin_sampler sampler_u (.first_pin_o(pin_a_o), .first_pin_oe(pin_a_oe), .second_pin_o(pin_b_o),
      .first_wire(wire_a), .second_wire(wire_b));

   initial
   begin
      forever #2 clk = ~clk;
   end

   // ==========================================
   // Checking and bus helpers
   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         err_total++;
         $display("FAIL at %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic bus(input logic [5:0] idx, input logic we, input logic [7:0] wd, output logic [7:0] rd);
      int n;
      n = 0;
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= {idx, 2'b00};
      wb_sel <= 4'h1;
      wb_wdat <= {24'h0, wd};
      do
      begin
         @(posedge clk);
         n++;
      end
      while (wb_ack !== 1'b1 && n < 40);
      rd = wb_rdat[7:0];
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_we <= 1'b0;
      if (wb_ack !== 1'b1)
      begin
         err_total++;
         conclude();
      end
      @(posedge clk);
   endtask

   // Model keeps only the plain read-write registers
   task automatic wr(input logic [5:0] idx, input logic [7:0] v);
      logic [7:0] d;
      bus(idx, 1'b1, v, d);
      if (idx inside {6'h16, 6'h17, 6'h18, 6'h1a, 6'h1d})
         reg_m[idx] = v;
   endtask

   task automatic rd_chk(input logic [5:0] idx, input logic [7:0] exp);
      logic [7:0] d;
      bus(idx, 1'b0, 8'h00, d);
      check(d, exp);
   endtask

   task automatic pin_chk();
      logic va, vb, a, b;
      int sa, sb, c;
      sa = reg_m['h18];
      sb = reg_m['h1a];
      c = reg_m['h17];
      va = &(rail_good | ~sa[5:0]) & !(sa[6] & thermal);
      vb = &(rail_good | ~sb[5:0]) & !(sb[6] & thermal);
      a = va ^ c[0];
      b = vb ^ c[4];
      check({7'h0, wire_a}, {7'h0, a});
      check({7'h0, wire_b}, {7'h0, b});
      check({6'h0, pin_a_oe, pin_a_o}, c[1] ? {6'h0, ~a, 1'b0} : {6'h0, 1'b1, a});
   endtask

   // ==========================================
   // Main sequence
   initial
   begin
      logic [7:0] v;
      void'($urandom(32'h54d6f339));
      @(posedge clk);
      for (int i = 0; i < 4; i++)
         otp[i] <= 8'($urandom);
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      reg_m['h16] = otp[0];
      reg_m['h17] = otp[1];
      reg_m['h18] = otp[2];
      reg_m['h1a] = otp[3];
      rd_chk('h16, otp[0]);
      rd_chk('h17, otp[1]);
      rd_chk('h18, otp[2]);
      for (int i = 0; i < 8; i++)
      begin
         v = {i[1:0], 2'($urandom), i[1:0], ~i[1:0]};
         wr('h16, v);
         rd_chk('h16, v);
         check({c_bw, c_bt, c_s2, c_s1}, v);
      end
      wr('h3f, 8'ha5);
      rd_chk('h3f, 8'h00);
      // Live gating only; latched gating is exercised below
      for (int i = 0; i < 24; i++)
      begin
         wr('h17, 8'($urandom) & 8'hbb);
         rd_chk('h17, reg_m['h17][7:0]);
         wr('h18, 8'($urandom) & 8'h7f);
         rd_chk('h18, reg_m['h18][7:0]);
         wr('h1a, 8'($urandom));
         rail_good <= 6'($urandom) | 6'($urandom);
         thermal <= 1'($urandom);
         repeat (6) @(posedge clk);
         pin_chk();
      end
      wr('h17, 8'h00);
      wr('h18, 8'h81);
      rail_good <= 6'h3e;
      thermal <= 1'b0;
      repeat (6) @(posedge clk);
      check({7'h0, wire_a}, 8'h00);
      rail_good <= 6'h3f;
      // Undelayed rise shows after 5 edges; the delay adds exactly RD
      repeat (RD + 4) @(posedge clk);
      check({7'h0, wire_a}, 8'h00);
      @(posedge clk);
      check({7'h0, wire_a}, 8'h01);
      rail_good <= 6'h3e;
      repeat (5) @(posedge clk);
      check({7'h0, wire_a}, 8'h00);
      wr('h18, 8'h01);
      rail_good <= 6'h3f;
      repeat (5) @(posedge clk);
      check({7'h0, wire_a}, 8'h01);
      wr('h17, 8'hcc);
      wr('h1a, 8'h02);
      bus('h19, 1'b1, 8'h7f, v);
      bus('h1b, 1'b1, 8'h7f, v);
      bus('h1c, 1'b1, 8'h07, v);
      wr('h1d, 8'h03);
      rail_good <= 6'h3c;
      repeat (6) @(posedge clk);
      rd_chk('h19, 8'h01);
      rd_chk('h1b, 8'h02);
      bus('h1c, 1'b0, 8'h00, v);
      check(v & 8'h03, 8'h03);
      check({6'h0, wire_b, wire_a}, 8'h00);
      check({7'h0, irq}, 8'h01);
      bus('h19, 1'b1, 8'h01, v);
      rd_chk('h19, 8'h01);
      rail_good <= 6'h3f;
      repeat (6) @(posedge clk);
      check({6'h0, wire_b, wire_a}, 8'h00);
      bus('h19, 1'b1, 8'h01, v);
      bus('h1b, 1'b1, 8'h02, v);
      rd_chk('h19, 8'h00);
      rd_chk('h1b, 8'h00);
      repeat (3) @(posedge clk);
      check({6'h0, wire_b, wire_a}, 8'h03);
      wr('h1d, 8'h00);
      repeat (2) @(posedge clk);
      check({7'h0, irq}, 8'h00);
      wr('h1d, 8'h03);
      repeat (2) @(posedge clk);
      check({7'h0, irq}, 8'h01);
      bus('h1c, 1'b1, 8'h07, v);
      repeat (2) @(posedge clk);
      check({7'h0, irq}, 8'h00);
      conclude();
   end
endmodule
